// ===== rtl/ddr3_cmd_decode.v
// Purpose: DDR3 command/control input decode, power state tracking
// Assumes: sys_clk stands for the CK rising / CK# falling crossing
// Notes: data path modelled only as burst length, latency checks and write-leveling feedback
`timescale 1ns/1ps
`include "ddr3_cmd_map.vh"

// Operation
// RULE_01: Sample inputs on CK rise crossing
// RULE_02: CKE gates clocks, buffers and drivers
// RULE_03: CKE low: precharge, self or active power-down
// RULE_04: Self-refresh exit on asynchronous CKE rise
// RULE_05: Controller holds CKE high during accesses
// RULE_06: Power-down keeps only CK, ODT, CKE buffers
// RULE_07: Self-refresh keeps only CKE buffer
// RULE_08: Chip select high masks the command
// RULE_09: Decode command from RAS, CAS, WE, CS
// RULE_10: A12 picks burst chop four or eight
// RULE_11: Controller refreshes every 7.8 or 3.9 us
// RULE_12: Controller waits 260 ns after refresh
// RULE_13: Controller enables extended or auto self-refresh
// RULE_14: Leveling feedback only on prime data line
// RULE_15: Support listed read, write, additive latencies
// RULE_16: Double-rate data with eight-word prefetch
// RULE_17: Row on activate, column on access, MRS opcode
// RULE_18: A10 auto-precharge or all-bank precharge
// RULE_19: Bank inputs pick bank or mode register
module ddr3_cmd_decode #(
	parameter ADDR_WIDTH = 15,
	parameter BANK_WIDTH = 3,
	parameter BANKS = 8
)(
	input wire sys_clk,
	input wire rstn,
	input wire cke,
	input wire csN,
	input wire rasN,
	input wire casN,
	input wire weN,
	input wire odt,
	input wire [BANK_WIDTH-1:0] bankAddr,
	input wire [ADDR_WIDTH-1:0] addr,
	input wire [3:0] casLatency,
	input wire [3:0] casWriteLatency,
	input wire [1:0] addLatencySel,
	input wire writeLevelEn,
	input wire dqsSample,
	output reg [2:0] cmdCode_q,
	output reg cmdValid_q,
	output reg [BANK_WIDTH-1:0] cmdBank_q,
	output reg [ADDR_WIDTH-1:0] rowAddr_q,
	output reg [`COL_WIDTH-1:0] colAddr_q,
	output reg [ADDR_WIDTH-1:0] mrOpcode_q,
	output reg autoPrecharge_q,
	output reg prechargeAll_q,
	output reg [3:0] burstLen_q,
	output reg [1:0] powerState_q,
	output reg internalClkEn_q,
	output reg cmdBufEn_q,
	output reg odtBufEn_q,
	output reg ckBufEn_q,
	output reg [BANKS-1:0] bankOpen_q,
	output reg latencyOk_q,
	output reg [3:0] additiveLatency_q,
	output reg [1:0] levelFeedback_q
);

////////////////////////////////////////////////////////////////////////////////
// Command capture

wire anyOpen = |bankOpen_q;
wire inSelf = (powerState_q == `ST_SREF);
wire inPd = (powerState_q == `ST_PPD) || (powerState_q == `ST_APD);
wire active = (powerState_q == `ST_IDLE) && cke; // [RULE_02]
wire [2:0] rawCmd = {rasN, casN, weN}; // [RULE_09]
wire selected = active && !csN; // [RULE_08]
wire isRdWr = (rawCmd == `CMD_RD) || (rawCmd == `CMD_WR);
wire [BANKS-1:0] bankOne = {{(BANKS-1){1'b0}}, 1'b1} << bankAddr;

// CKE low with a self-refresh command and no bank open enters self-refresh, else power-down
wire selfEntry = (powerState_q == `ST_IDLE) && !cke && !csN && (rawCmd == `CMD_REF);

////////////////////////////////////////////////////////////////////////////////
// Latency check: CL 6..11,13,14; CWL 5..10; AL 0, CL-1, CL-2

reg [3:0] alDec;
always @*
begin
	case (addLatencySel)
		2'h1: alDec = casLatency - 4'h1;
		2'h2: alDec = casLatency - 4'h2;
		default: alDec = 4'h0;
	endcase
end

wire [15:0] clMask = `CL_VALID_MASK;
wire clOk = clMask[casLatency];
wire cwlOk = (casWriteLatency >= `CWL_MIN) && (casWriteLatency <= `CWL_MAX);
wire alOk = (addLatencySel != 2'h3);

////////////////////////////////////////////////////////////////////////////////
// Power state machine

// Self-refresh exit: CKE rise is caught without a clock edge, since CK may be
// stopped in self-refresh; a toggle, so no stale wake outlives its exit
reg wakeToggle_q;
reg wakeSeen_q;
always @(posedge cke or negedge rstn)
begin
	if (!rstn)
		wakeToggle_q <= 1'b0;
	else if (inSelf)
		wakeToggle_q <= ~wakeToggle_q; // [RULE_04]
end

wire srefWake = inSelf && (wakeToggle_q != wakeSeen_q);

reg [1:0] powerState_d;
always @*
begin
	powerState_d = powerState_q;
	case (powerState_q)
		`ST_IDLE:
		begin
			if (selfEntry && !anyOpen)
				powerState_d = `ST_SREF; // [RULE_03]
			else if (!cke)
				powerState_d = anyOpen ? `ST_APD : `ST_PPD; // [RULE_03]
		end
		`ST_PPD, `ST_APD:
		begin
			if (cke)
				powerState_d = `ST_IDLE;
		end
		`ST_SREF:
		begin
			if (cke || srefWake)
				powerState_d = `ST_IDLE; // [RULE_04]
		end
		default: powerState_d = `ST_IDLE;
	endcase
end

always @(posedge sys_clk or negedge rstn)
begin
	if (!rstn)
	begin
		powerState_q <= `ST_IDLE;
		wakeSeen_q <= 1'b0;
		internalClkEn_q <= 1'b0;
		cmdBufEn_q <= 1'b0;
		odtBufEn_q <= 1'b0;
		ckBufEn_q <= 1'b0;
	end
	else
	begin
		powerState_q <= powerState_d;
		wakeSeen_q <= wakeToggle_q;
		internalClkEn_q <= (powerState_d == `ST_IDLE) && cke; // [RULE_02]
		cmdBufEn_q <= (powerState_d == `ST_IDLE); // [RULE_06] [RULE_07]
		odtBufEn_q <= (powerState_d != `ST_SREF); // [RULE_06] [RULE_07]
		ckBufEn_q <= (powerState_d != `ST_SREF); // [RULE_07]
	end
end

////////////////////////////////////////////////////////////////////////////////
// Command decode and address split

always @(posedge sys_clk or negedge rstn)
begin
	if (!rstn)
	begin
		cmdCode_q <= `CMD_NOP;
		cmdValid_q <= 1'b0;
		cmdBank_q <= {BANK_WIDTH{1'b0}};
		rowAddr_q <= {ADDR_WIDTH{1'b0}};
		colAddr_q <= {`COL_WIDTH{1'b0}};
		mrOpcode_q <= {ADDR_WIDTH{1'b0}};
		autoPrecharge_q <= 1'b0;
		prechargeAll_q <= 1'b0;
		burstLen_q <= `BURST_FULL;
		bankOpen_q <= {BANKS{1'b0}};
		latencyOk_q <= 1'b0;
		additiveLatency_q <= 4'h0;
		levelFeedback_q <= 2'h0;
	end
	else
	begin
		cmdValid_q <= selected && (rawCmd != `CMD_NOP); // [RULE_01] [RULE_08]
		cmdCode_q <= selected ? rawCmd : `CMD_NOP; // [RULE_09]
		latencyOk_q <= clOk && cwlOk && alOk; // [RULE_15]
		additiveLatency_q <= alDec; // [RULE_15]
		// Only the prime line of each byte lane carries strobe feedback
		levelFeedback_q <= writeLevelEn ? {dqsSample, dqsSample} : 2'h0; // [RULE_14]
		if (selected)
		begin
			cmdBank_q <= bankAddr; // [RULE_19]
			case (rawCmd)
				`CMD_ACT:
				begin
					rowAddr_q <= addr; // [RULE_17]
					bankOpen_q <= bankOpen_q | bankOne;
				end
				`CMD_RD, `CMD_WR:
				begin
					colAddr_q <= addr[`COL_WIDTH-1:0]; // [RULE_17]
					autoPrecharge_q <= addr[`ADDR_AP_BIT]; // [RULE_18]
					// High: full burst; low: chopped to four
					burstLen_q <= addr[`ADDR_BC_BIT] ? `BURST_FULL : `BURST_CHOP; // [RULE_10] [RULE_16]
					if (addr[`ADDR_AP_BIT])
						bankOpen_q <= bankOpen_q & ~bankOne; // [RULE_18]
				end
				`CMD_PRE:
				begin
					prechargeAll_q <= addr[`ADDR_AP_BIT]; // [RULE_18]
					bankOpen_q <= addr[`ADDR_AP_BIT] ? {BANKS{1'b0}} : (bankOpen_q & ~bankOne);
				end
				`CMD_MRS:
					mrOpcode_q <= addr; // [RULE_17] [RULE_19]
				default:
					autoPrecharge_q <= autoPrecharge_q;
			endcase
			if (!isRdWr)
				autoPrecharge_q <= 1'b0;
		end
	end
end

endmodule

// ===== common/ddr3_cmd_map.vh
// Purpose: constants for the DDR3 command input block
// Assumes: plain Verilog-2005, included by bare name
// Notes: command codes are {rasN, casN, weN}
`ifndef DDR3_CMD_MAP_VH
`define DDR3_CMD_MAP_VH
`define CMD_MRS 3'h0
`define CMD_REF 3'h1
`define CMD_PRE 3'h2
`define CMD_ACT 3'h3
`define CMD_WR 3'h4
`define CMD_ZQ 3'h6
`define CMD_RD 3'h5
`define CMD_NOP 3'h7
`define ADDR_AP_BIT 10
`define ADDR_BC_BIT 12
`define COL_WIDTH 10
`define ST_IDLE 2'h0
`define ST_PPD 2'h1
`define ST_APD 2'h2
`define ST_SREF 2'h3
`define CL_VALID_MASK 16'h6FC0
`define CWL_MIN 4'h5
`define CWL_MAX 4'hA
`define BURST_FULL 4'h8
`define BURST_CHOP 4'h4
`define PREFETCH_WORDS 4'h8
`endif

// ===== dv/ddr3_cmd_decode_asserts.sv
// Purpose: port checks for ddr3_cmd_decode
// Assumes: one clock, async low reset
// Notes: bound below
`timescale 1ns/1ps
module ddr3_cmd_decode_asserts(
	input wire sys_clk,
	input wire rstn,
	input wire cke,
	input wire csN,
	input wire rasN,
	input wire casN,
	input wire weN,
	input wire [14:0] addr,
	input wire [2:0] cmdCode_q,
	input wire cmdValid_q,
	input wire autoPrecharge_q,
	input wire [3:0] burstLen_q,
	input wire [1:0] powerState_q,
	input wire internalClkEn_q,
	input wire cmdBufEn_q,
	input wire odtBufEn_q,
	input wire ckBufEn_q,
	input wire [7:0] bankOpen_q
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rstn);
wire take = cke && !csN && powerState_q == 2'h0 && {rasN, casN, weN} != 3'h7;
wire acc = cmdValid_q && cmdCode_q[2:1] == 2'b10;
chk_cs_mask: assert property (csN |=> !cmdValid_q) else $error("masked cmd");
chk_cmd_decode: assert property (take |=> cmdValid_q &&
	cmdCode_q == {$past(rasN), $past(casN), $past(weN)}) else $error("bad code");
chk_burst_sel: assert property (acc |-> burstLen_q == ($past(addr[12]) ? 4'h8 : 4'h4))
	else $error("bad burst");
chk_auto_pre: assert property (acc |-> autoPrecharge_q == $past(addr[10]))
	else $error("bad ap");
chk_apd_entry: assert property (!cke && powerState_q == 2'h0 && bankOpen_q != 8'h00
	|=> powerState_q == 2'h2 && !cmdBufEn_q) else $error("no apd");
chk_pd_bufs: assert property (powerState_q == 2'h1 |-> ckBufEn_q && odtBufEn_q
	&& !cmdBufEn_q && !internalClkEn_q) else $error("pd bufs");
chk_sref_bufs: assert property (powerState_q == 2'h3 |-> !(ckBufEn_q | odtBufEn_q | cmdBufEn_q))
	else $error("sr bufs");
chk_sref_exit: assert property (powerState_q == 2'h3 && cke |=> powerState_q == 2'h0)
	else $error("no sr exit");
cover property (powerState_q == 2'h2);
cover property (powerState_q == 2'h3);
cover property (acc && burstLen_q == 4'h4);
endmodule
////////////////////////////////////////
bind ddr3_cmd_decode ddr3_cmd_decode_asserts chk(.sys_clk, .rstn, .cke, .csN, .rasN, .casN,
	.weN, .addr, .cmdCode_q, .cmdValid_q, .autoPrecharge_q, .burstLen_q, .powerState_q,
	.internalClkEn_q, .cmdBufEn_q, .odtBufEn_q, .ckBufEn_q, .bankOpen_q);

// ===== dv/ddr3_ctrl_model.sv
// Purpose: memory controller stand-in
// Assumes: drives on falling edge
// Notes: released bank and address lines show inverted values; command lines go high
`timescale 1ns/1ps
`include "ddr3_cmd_map.vh"
module ddr3_ctrl_model(
	input wire sys_clk,
	output reg cke,
	output reg csN,
	output reg rasN,
	output reg casN,
	output reg weN,
	output reg [2:0] bankAddr,
	output reg [14:0] addr
);
initial {cke, csN, rasN, casN, weN, bankAddr, addr} = {5'h1F, 3'h0, 15'h0};
task cmd(input [2:0] c, input [2:0] b, input [14:0] a, input k, input s);
begin
	@(negedge sys_clk);
	// Accesses always go out with CKE high
	cke = (c == `CMD_RD || c == `CMD_WR) ? 1'b1 : k;
	csN = s;
	{rasN, casN, weN} = c;
	bankAddr = b;
	addr = a;
	@(negedge sys_clk);
	{csN, rasN, casN, weN} = 4'hF;
	bankAddr = ~b;
	addr = ~a;
	if (c == `CMD_REF)
		repeat (7) @(negedge sys_clk);
end
endtask
endmodule

// ===== dv/ddr3_cmd_decode_tb_top.sv
// Purpose: directed tests of ddr3_cmd_decode
// Assumes: 25 MHz clock
// Notes: odt tied high; its value is not used by the block
`timescale 1ns/1ps
`include "ddr3_cmd_map.vh"
module ddr3_cmd_decode_tb_top;
reg sys_clk = 0, rstn = 0, wl = 0, dqs = 0;
reg [3:0] cl = 4'h6, cwl = 4'h5;
reg [1:0] al = 2'h0;
integer errors = 0, n_compared = 0, i;
// Extended self-refresh enable word sent after the self-refresh round trips; value arbitrary
localparam [14:0] HOT_MR_WORD = 15'h0040;
wire cke, csN, rasN, casN, weN, val, ap, pall, cbuf, ckEn, obuf, kbuf, lok;
wire [2:0] ba, code, bank;
wire [14:0] a, row, mr;
wire [9:0] col;
wire [3:0] bl, alo;
wire [1:0] ps, fb;
wire [7:0] open;
always #20 sys_clk = ~sys_clk;
ddr3_ctrl_model M(.sys_clk, .cke, .csN, .rasN, .casN, .weN, .bankAddr(ba), .addr(a));
ddr3_cmd_decode DUT(.sys_clk, .rstn, .cke, .csN, .rasN, .casN, .weN, .odt(1'b1), .bankAddr(ba),
	.addr(a), .casLatency(cl), .casWriteLatency(cwl), .addLatencySel(al), .writeLevelEn(wl),
	.dqsSample(dqs), .cmdCode_q(code), .cmdValid_q(val), .cmdBank_q(bank), .rowAddr_q(row),
	.colAddr_q(col), .mrOpcode_q(mr), .autoPrecharge_q(ap), .prechargeAll_q(pall),
	.burstLen_q(bl), .powerState_q(ps), .internalClkEn_q(ckEn), .cmdBufEn_q(cbuf),
	.odtBufEn_q(obuf), .ckBufEn_q(kbuf), .bankOpen_q(open), .latencyOk_q(lok),
	.additiveLatency_q(alo), .levelFeedback_q(fb));
task chk(input [31:0] g, input [31:0] e);
begin
	n_compared = n_compared + 1;
	if (g !== e)
	begin
		errors = errors + 1;
		$display("MISMATCH %0t got %h exp %h", $time, g, e);
	end
end
endtask
task stop_test;
begin
	$display("errors %0d compared %0d", errors, n_compared);
	if (errors == 0 && n_compared > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
end
endtask
////////////////////////////////////////
initial
begin
	repeat (8) @(negedge sys_clk);
	rstn = 1;
	M.cmd(`CMD_ACT, 3'h2, 15'h1234, 1, 0);
	chk({val, code, row, bank}, {1'b1, `CMD_ACT, 15'h1234, 3'h2});
	M.cmd(`CMD_RD, 3'h2, 15'h0405, 1, 0);
	chk({bl, ap, col, open}, {4'h4, 1'b1, 10'h005, 8'h00});
	M.cmd(`CMD_WR, 3'h1, 15'h1000, 1, 1);
	chk({val, code}, {1'b0, `CMD_NOP});
	M.cmd(`CMD_WR, 3'h1, 15'h1000, 1, 0);
	chk({val, bl, ap}, {1'b1, 4'h8, 1'b0});
	M.cmd(`CMD_ACT, 3'h3, 15'h0000, 1, 0);
	M.cmd(`CMD_ACT, 3'h5, 15'h0000, 1, 0);
	M.cmd(`CMD_NOP, 3'h0, 15'h0000, 0, 0);
	chk({ps, cbuf, open}, {2'h2, 1'b0, 8'h28});
	M.cmd(`CMD_NOP, 3'h0, 15'h0000, 1, 0);
	M.cmd(`CMD_PRE, 3'h3, 15'h0000, 1, 0);
	chk({pall, open}, {1'b0, 8'h20});
	M.cmd(`CMD_PRE, 3'h0, 15'h0400, 1, 0);
	chk({pall, open}, {1'b1, 8'h00});
	M.cmd(`CMD_NOP, 3'h0, 15'h0000, 0, 0);
	chk({ps, ckEn, cbuf, obuf, kbuf}, {2'h1, 4'h3});
	M.cmd(`CMD_NOP, 3'h0, 15'h0000, 1, 0);
	for (i = 0; i < 2; i = i + 1)
	begin
		M.cmd(`CMD_REF, 3'h0, 15'h0000, 0, 0);
		chk({ps, cbuf, obuf, kbuf}, {2'h3, 3'h0});
		M.cmd(`CMD_NOP, 3'h0, 15'h0000, 1, 0);
		chk(ps, 2'h0);
	end
	M.cmd(`CMD_MRS, 3'h2, HOT_MR_WORD, 1, 0);
	chk({val, code, bank, mr}, {1'b1, `CMD_MRS, 3'h2, HOT_MR_WORD});
	M.cmd(`CMD_ACT, 3'h1, 15'h0000, 1, 0);
	rstn = 0;
	@(negedge sys_clk);
	chk({val, code, bl, open, ckEn, cbuf}, {1'b0, `CMD_NOP, 4'h8, 8'h00, 2'h0});
	rstn = 1;
	for (i = 0; i < 16; i = i + 1)
	begin
		@(negedge sys_clk);
		cl = i[3:0];
		@(negedge sys_clk);
		chk(lok, (`CL_VALID_MASK >> i) & 1);
	end
	cl = 4'h6;
	cwl = 4'h4;
	@(negedge sys_clk);
	chk(lok, 0);
	cwl = 4'hA;
	al = 2'h1;
	@(negedge sys_clk);
	chk({lok, alo}, {1'b1, 4'h5});
	cwl = 4'hB;
	al = 2'h2;
	@(negedge sys_clk);
	chk({lok, alo}, {1'b0, 4'h4});
	cwl = 4'h5;
	al = 2'h3;
	@(negedge sys_clk);
	chk(lok, 0);
	wl = 1;
	dqs = 1;
	@(negedge sys_clk);
	chk(fb, 2'h3);
	wl = 0;
	@(negedge sys_clk);
	chk(fb, 2'h0);
	stop_test;
end
initial
begin
	#100000;
	errors = errors + 1;
	stop_test;
end
endmodule
